// [core/lcps_pkg.sv]
// constants shared by the lcd colour pin select block
// What this block does
// R1 - option bits live in pin_function_select_0 register
// R2 - reduced bit meant for blue_bit2, red_bit2
// R3 - reduced bit alone leaves both pins gpio
// R4 - software sets full bit for those colours
// R5 - full bit: all eight pins colour
// R6 - full bit: six more pins lose gpio
// R7 - reads return written bits; routing follows writes

package lcps_pkg;

   // ------------------------------------------------------------
   // bus and pin widths
   // ------------------------------------------------------------
   localparam int LCPS_AW   = 32;
   localparam int LCPS_DW   = 32;
   localparam int LCPS_PINS = 8;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] LCPS_SEL_ADDR   = 32'h01c4_0000;
   localparam logic [31:0] LCPS_ROUTE_ADDR = 32'h01c4_0004;
   localparam logic [31:0] LCPS_PAD_ADDR   = 32'h01c4_0008;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int LCPS_FULL_BIT    = 23; // full_colour_lcd_option
   localparam int LCPS_REDUCED_BIT = 22; // reduced_colour_lcd_option
   localparam int LCPS_INEFF_BIT   = 8;  // route status: reduced ignored

   // ------------------------------------------------------------
   // values after reset and pin masks
   // ------------------------------------------------------------
   localparam logic [31:0] LCPS_SEL_RESET    = 32'h0000_0000;
   localparam logic [31:0] LCPS_ZERO_WORD    = 32'h0000_0000;
   localparam logic [7:0]  LCPS_PIN_RESET    = 8'h00;
   localparam logic [7:0]  LCPS_ALL_PINS     = 8'hff;
   localparam logic [7:0]  LCPS_NO_PINS      = 8'h00;
   // pins the reduced option was meant to claim
   localparam logic [7:0]  LCPS_REDUCED_PINS = 8'h03;

   // ------------------------------------------------------------
   // pin index: colour function / gpio function
   // ------------------------------------------------------------
   localparam int LCPS_PIN_BLUE2  = 0; // blue_bit2  / general_io_47
   localparam int LCPS_PIN_RED2   = 1; // red_bit2   / general_io_46
   localparam int LCPS_PIN_RED1   = 2; // red_bit1   / general_io_38
   localparam int LCPS_PIN_BLUE1  = 3; // blue_bit1  / general_io_6
   localparam int LCPS_PIN_GREEN1 = 4; // green_bit1 / general_io_5
   localparam int LCPS_PIN_RED0   = 5; // red_bit0   / general_io_4
   localparam int LCPS_PIN_BLUE0  = 6; // blue_bit0  / general_io_3
   localparam int LCPS_PIN_GREEN0 = 7; // green_bit0 / general_io_2

endpackage : lcps_pkg

// [core/lcps_pin_sync.sv]
// three-stage synchroniser with agreement filter for pad inputs
`timescale 1ns/1ns
`default_nettype none

module lcps_pin_sync (
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] pad_in,
   output logic      [lcps_pkg::LCPS_PINS-1:0] pad_level
);
   import lcps_pkg::*;

   logic [LCPS_PINS-1:0] s1_reg;
   logic [LCPS_PINS-1:0] s2_reg;
   logic [LCPS_PINS-1:0] s3_reg;
   logic [LCPS_PINS-1:0] level_reg;
   logic [LCPS_PINS-1:0] level_next;

   // accept a level only once stages two and three agree
   always_comb begin
      level_next = level_reg;
      for (int i = 0; i < LCPS_PINS; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            level_next[i] = s3_reg[i];
         end
      end
   end

   // s1 feeds s2 only, so metastability never reaches the filter
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_reg    <= LCPS_PIN_RESET;
         s2_reg    <= LCPS_PIN_RESET;
         s3_reg    <= LCPS_PIN_RESET;
         level_reg <= LCPS_PIN_RESET;
      end else begin
         s1_reg    <= pad_in;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign pad_level = level_reg;

endmodule : lcps_pin_sync
`default_nettype wire

// [core/lcps_pin_route.sv]
// per-pin mux between gpio and lcd colour functions
`timescale 1ns/1ns
`default_nettype none

module lcps_pin_route (
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] colour_mask,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] gpio_out,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] gpio_oe,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] lcd_colour_data,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] pad_level,
   output logic      [lcps_pkg::LCPS_PINS-1:0] pad_out,
   output logic      [lcps_pkg::LCPS_PINS-1:0] pad_oe,
   output logic      [lcps_pkg::LCPS_PINS-1:0] gpio_in
);
   import lcps_pkg::*;

   logic [LCPS_PINS-1:0] out_reg;
   logic [LCPS_PINS-1:0] out_next;
   logic [LCPS_PINS-1:0] oe_reg;
   logic [LCPS_PINS-1:0] oe_next;
   logic [LCPS_PINS-1:0] in_reg;
   logic [LCPS_PINS-1:0] in_next;

   // colour pins always drive the panel; gpio reads zero there
   for (genvar p = 0; p < LCPS_PINS; p++) begin : g_pin
      assign out_next[p] = colour_mask[p] ? lcd_colour_data[p]
                                          : gpio_out[p];
      assign oe_next[p]  = colour_mask[p] | gpio_oe[p];
      assign in_next[p]  = colour_mask[p] ? 1'b0 : pad_level[p]; // see R6
   end

   // registered so pads never see a mux glitch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_reg <= LCPS_PIN_RESET;
         oe_reg  <= LCPS_PIN_RESET;
         in_reg  <= LCPS_PIN_RESET;
      end else begin
         out_reg <= out_next;
         oe_reg  <= oe_next;
         in_reg  <= in_next;
      end
   end

   assign pad_out = out_reg;
   assign pad_oe  = oe_reg;
   assign gpio_in = in_reg;

endmodule : lcps_pin_route
`default_nettype wire

// [core/lcps_pin_select.sv]
// top of the lcd colour pin select block with its register port
`timescale 1ns/1ns
`default_nettype none

module lcps_pin_select (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic [lcps_pkg::LCPS_AW-1:0]   reg_addr,
   input  wire logic [lcps_pkg::LCPS_DW-1:0]   reg_wr_data,
   input  wire logic                         reg_wr_stb,
   input  wire logic                         reg_rd_stb,
   output logic      [lcps_pkg::LCPS_DW-1:0]   reg_rd_data,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] gpio_out,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] gpio_oe,
   output logic      [lcps_pkg::LCPS_PINS-1:0] gpio_in,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] lcd_colour_data,
   input  wire logic [lcps_pkg::LCPS_PINS-1:0] pad_in,
   output logic      [lcps_pkg::LCPS_PINS-1:0] pad_out,
   output logic      [lcps_pkg::LCPS_PINS-1:0] pad_oe
);
   import lcps_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [LCPS_DW-1:0]   sel_reg;
   logic [LCPS_DW-1:0]   sel_next;
   logic [LCPS_DW-1:0]   rd_data_reg;
   logic [LCPS_DW-1:0]   rd_data_next;
   logic [LCPS_PINS-1:0] colour_mask;
   logic [LCPS_PINS-1:0] pad_level;
   logic                 full_on;
   logic                 reduced_on;
   logic                 reduced_ignored;
   logic                 hit_sel;
   logic                 hit_route;
   logic                 hit_pad;
   logic                 sel_write;
   logic [LCPS_DW-1:0]   route_word;
   logic [LCPS_DW-1:0]   pad_word;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------

   // full-word compare; aliases would hide software bugs
   assign hit_sel   = (reg_addr == LCPS_SEL_ADDR);   // see R1
   assign hit_route = (reg_addr == LCPS_ROUTE_ADDR);
   assign hit_pad   = (reg_addr == LCPS_PAD_ADDR);
   assign sel_write = reg_wr_stb & hit_sel;

   // ------------------------------------------------------------
   // pin selection register
   // ------------------------------------------------------------

   // every bit is kept as written, including unused options
   always_comb begin
      sel_next = sel_reg;
      if (sel_write) begin
         sel_next = reg_wr_data; // see R7
      end
   end

   // state only moves on a write to the selection address
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sel_reg <= LCPS_SEL_RESET;
      end else begin
         sel_reg <= sel_next;
      end
   end

   // ------------------------------------------------------------
   // option decode
   // ------------------------------------------------------------

   // option bits pulled out for the routing logic
   assign full_on    = sel_reg[LCPS_FULL_BIT];
   assign reduced_on = sel_reg[LCPS_REDUCED_BIT];

   // the reduced option has no path to the pins in this silicon;
   // only the full option claims pins, for all eight at once
   always_comb begin
      colour_mask = LCPS_NO_PINS; // see R3
      if (full_on) begin
         colour_mask = LCPS_ALL_PINS; // see R5
      end
   end

   // software asked for the reduced option and got nothing
   assign reduced_ignored = reduced_on & ~full_on; // see R2

   // ------------------------------------------------------------
   // pad input synchroniser
   // ------------------------------------------------------------

   // pads are asynchronous to clk, hence the three stages
   lcps_pin_sync u_sync (
      .clk       (clk),
      .reset     (reset),
      .pad_in    (pad_in),
      .pad_level (pad_level)
   );

   // ------------------------------------------------------------
   // per-pin routing
   // ------------------------------------------------------------

   // one cycle from mask change to pad change
   lcps_pin_route u_route (
      .clk             (clk),
      .reset           (reset),
      .colour_mask     (colour_mask),
      .gpio_out        (gpio_out),
      .gpio_oe         (gpio_oe),
      .lcd_colour_data (lcd_colour_data),
      .pad_level       (pad_level),
      .pad_out         (pad_out),
      .pad_oe          (pad_oe),
      .gpio_in         (gpio_in)
   );

   // ------------------------------------------------------------
   // status words
   // ------------------------------------------------------------

   // route status: live colour mask and the ignored-option flag
   always_comb begin
      route_word                 = LCPS_ZERO_WORD;
      route_word[LCPS_PINS-1:0]  = colour_mask;
      route_word[LCPS_INEFF_BIT] = reduced_ignored;
   end

   // pad status: filtered pad levels, whatever the pin function
   always_comb begin
      pad_word                = LCPS_ZERO_WORD;
      pad_word[LCPS_PINS-1:0] = pad_level;
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------

   // data stands one cycle only; unmapped addresses read zero
   always_comb begin
      rd_data_next = LCPS_ZERO_WORD;
      if (reg_rd_stb) begin
         if (hit_sel) begin
            rd_data_next = sel_reg; // see R7
         end else if (hit_route) begin
            rd_data_next = route_word;
         end else if (hit_pad) begin
            rd_data_next = pad_word;
         end
      end
   end

   // read data comes from a flip-flop, never straight from decode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_data_reg <= LCPS_ZERO_WORD;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign reg_rd_data = rd_data_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------

   // a write to the selection address lands whole
   chk_sel_write_lands: assert property ( // see R1
      @(posedge clk) disable iff (reset)
      (reg_wr_stb && reg_addr == LCPS_SEL_ADDR)
         |=> (sel_reg == $past(reg_wr_data)))
      else $error("selection register missed a write");

   // without a write the selection holds still
   chk_sel_holds: assert property ( // see R7
      @(posedge clk) disable iff (reset)
      !(reg_wr_stb && reg_addr == LCPS_SEL_ADDR)
         |=> $stable(sel_reg))
      else $error("selection changed without a write");

   // a read of the selection returns what was last written
   chk_sel_readback: assert property ( // see R7
      @(posedge clk) disable iff (reset)
      (reg_wr_stb && reg_addr == LCPS_SEL_ADDR)
         ##1 (reg_rd_stb && reg_addr == LCPS_SEL_ADDR
              && !reg_wr_stb)
         |=> (reg_rd_data == $past(reg_wr_data, 2)))
      else $error("readback differs from last write");

   // reduced option alone never drives colour
   chk_reduced_ignored: assert property ( // see R3
      @(posedge clk) disable iff (reset)
      (!sel_reg[LCPS_FULL_BIT] && sel_reg[LCPS_REDUCED_BIT])
         |=> (pad_oe == $past(gpio_oe)
              && pad_out == $past(gpio_out)))
      else $error("reduced option moved a pin to colour");

   // full option puts colour on all eight pins
   chk_full_all_pins: assert property ( // see R5
      @(posedge clk) disable iff (reset)
      sel_reg[LCPS_FULL_BIT]
         |=> (pad_oe == LCPS_ALL_PINS
              && pad_out == $past(lcd_colour_data)))
      else $error("full option not on every pin");

   // blue_bit2 and red_bit2 reach their pins with the full option
   chk_blue_red_full: assert property ( // see R2
      @(posedge clk) disable iff (reset)
      sel_reg[LCPS_FULL_BIT]
         |=> (pad_out[LCPS_PIN_RED2:LCPS_PIN_BLUE2]
              == $past(lcd_colour_data[LCPS_PIN_RED2:LCPS_PIN_BLUE2])))
      else $error("blue_bit2 or red_bit2 missing");

   // both options clear leaves plain gpio
   chk_gpio_when_off: assert property ( // see R5
      @(posedge clk) disable iff (reset)
      (sel_reg[LCPS_FULL_BIT:LCPS_REDUCED_BIT] == 2'b00)
         |=> (pad_oe == $past(gpio_oe)
              && pad_out == $past(gpio_out)))
      else $error("gpio not routed with options clear");

   // colour pins show nothing to the gpio controller
   chk_gpio_in_lost: assert property ( // see R6
      @(posedge clk) disable iff (reset)
      sel_reg[LCPS_FULL_BIT] |=> (gpio_in == LCPS_NO_PINS))
      else $error("gpio input live on a colour pin");

   // route status flag tracks the ignored reduced request
   chk_status_flag: assert property ( // see R3
      @(posedge clk) disable iff (reset)
      (reg_rd_stb && reg_addr == LCPS_ROUTE_ADDR)
         |=> (reg_rd_data[LCPS_INEFF_BIT]
              == $past(sel_reg[LCPS_REDUCED_BIT]
                       && !sel_reg[LCPS_FULL_BIT])))
      else $error("route status flag wrong");

   // ------------------------------------------------------------
   // covers
   // ------------------------------------------------------------

   // software enables full colour
   cov_full_on: cover property (
      @(posedge clk) disable iff (reset)
      $rose(sel_reg[LCPS_FULL_BIT]));

   // software tries the reduced option alone
   cov_reduced_only: cover property (
      @(posedge clk) disable iff (reset)
      $rose(reduced_ignored));

   // full colour dropped back to gpio
   cov_back_to_gpio: cover property (
      @(posedge clk) disable iff (reset)
      $fell(sel_reg[LCPS_FULL_BIT]) ##1 (pad_oe == gpio_oe));

   // write then immediate readback
   cov_write_read: cover property (
      @(posedge clk) disable iff (reset)
      sel_write ##1 (reg_rd_stb && hit_sel));

endmodule : lcps_pin_select
`default_nettype wire

// [test/lcps_panel_model.sv]
// external display panel and pad wire model for the pin select bench
`timescale 1ns/1ns
`default_nettype none

module lcps_panel_model (
   input  wire logic       clk,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pad_in,
   output logic      [7:0] rx_colour
);
   logic [7:0] flip_reg = 8'h00;

   // ----------------------------------------------------------------
   // wire level
   // ----------------------------------------------------------------
   // undriven pads toggle each cycle so a stale level never passes
   always_comb begin
      pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
             | (~pad_oe & ~ext_en & flip_reg);
   end

   // panel samples the colour lines on every rising edge
   always_ff @(posedge clk) begin
      flip_reg  <= ~flip_reg;
      rx_colour <= pad_in;
   end
endmodule : lcps_panel_model
`default_nettype wire

// [test/lcps_pin_select_tb.sv]
// self-checking bench for the lcd colour pin select block
`timescale 1ns/1ns
`default_nettype none

module lcps_pin_select_tb;
   import lcps_pkg::*;

   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [31:0] reg_addr = 32'h0000_0000;
   logic [31:0] reg_wr_data = 32'h0000_0000;
   logic        reg_wr_stb = 1'b0;
   logic        reg_rd_stb = 1'b0;
   logic [31:0] reg_rd_data;
   logic [7:0]  gpio_out = 8'ha5;
   logic [7:0]  gpio_oe = 8'h0f;
   logic [7:0]  gpio_in;
   logic [7:0]  lcd_colour_data = 8'hc3;
   logic [7:0]  pad_in;
   logic [7:0]  pad_out;
   logic [7:0]  pad_oe;
   logic [7:0]  ext_en = 8'hff;
   logic [7:0]  ext_val = 8'h3c;
   logic [7:0]  rx_colour;
   int          bad_count = 0;
   int          num_checks = 0;

   always #2 clk = ~clk;

   lcps_pin_select u_dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
      .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
      .lcd_colour_data(lcd_colour_data), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe)
   );

   lcps_panel_model u_panel (
      .clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in), .rx_colour(rx_colour)
   );

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe, released at the next edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr_stb  <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= d;
      @(posedge clk);
      reg_wr_stb <= 1'b0;
   endtask : wr

   // data stand only in the cycle after the read edge
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd_stb <= 1'b1;
      reg_addr   <= a;
      @(posedge clk);
      reg_rd_stb <= 1'b0;
      #1;
      d = reg_rd_data;
   endtask : rd

   // write strobe then read strobe on the very next edge, no gap
   task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] d);
      @(posedge clk);
      reg_wr_stb  <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= wd;
      @(posedge clk);
      reg_wr_stb <= 1'b0;
      reg_rd_stb <= 1'b1;
      @(posedge clk);
      reg_rd_stb <= 1'b0;
      #1;
      d = reg_rd_data;
   endtask : wr_rd

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [31:0] sel_tab [4];
      logic [7:0]  wire_exp;
      logic        full;
      logic [7:0]  oe_exp;
      logic [7:0]  out_exp;
      logic [7:0]  in_exp;
      logic [7:0]  lvl_exp;
      sel_tab = '{32'h0000_0000, 32'h0040_0000, 32'h0080_0000,
                  32'h00c0_0000};
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(LCPS_SEL_ADDR, d);
      chk(d, LCPS_SEL_RESET);
      chk({24'h0, pad_oe}, {24'h0, gpio_oe});
      $display("test reset done");

      // every option setting, gpio pins partly driven by the panel side
      wire_exp = (gpio_oe & gpio_out) | (~gpio_oe & ext_val);
      for (int i = 0; i < 4; i++) begin
         full = sel_tab[i][LCPS_FULL_BIT];
         oe_exp  = full ? LCPS_ALL_PINS : gpio_oe;
         out_exp = full ? lcd_colour_data : gpio_out;
         in_exp  = full ? LCPS_NO_PINS : wire_exp;
         lvl_exp = full ? lcd_colour_data : wire_exp;
         wr(LCPS_SEL_ADDR, sel_tab[i]);
         repeat (8) @(posedge clk);
         #1;
         chk({24'h0, pad_oe}, {24'h0, oe_exp});
         chk({24'h0, pad_out}, {24'h0, out_exp});
         chk({24'h0, gpio_in}, {24'h0, in_exp});
         chk({24'h0, rx_colour}, {24'h0, lvl_exp});
         rd(LCPS_PAD_ADDR, d);
         chk(d, {24'h0, lvl_exp});
         rd(LCPS_SEL_ADDR, d);
         chk(d, sel_tab[i]);
         rd(LCPS_ROUTE_ADDR, d);
         chk(d, {23'h0, sel_tab[i][22] & ~full,
                 full ? LCPS_ALL_PINS : LCPS_NO_PINS});
      end
      $display("test option table done");

      // panel lines follow the colour data one cycle later in full mode
      @(posedge clk);
      lcd_colour_data <= 8'h5a;
      gpio_out        <= 8'hff;
      @(posedge clk);
      #1;
      chk({24'h0, pad_out}, 32'h0000_005a);
      chk({24'h0, pad_oe}, {24'h0, LCPS_ALL_PINS});
      $display("test colour follow done");

      // full word read back, read data gone the next cycle
      wr(LCPS_SEL_ADDR, 32'h5ac0_3ca5);
      rd(LCPS_SEL_ADDR, d);
      chk(d, 32'h5ac0_3ca5);
      @(posedge clk);
      #1;
      chk(reg_rd_data, LCPS_ZERO_WORD);
      wr(LCPS_ROUTE_ADDR, 32'h0000_0000);
      rd(LCPS_SEL_ADDR, d);
      chk(d, 32'h5ac0_3ca5);
      rd(32'h01c4_000c, d);
      chk(d, LCPS_ZERO_WORD);
      // back-to-back write and read, full option dropped to reduced
      wr_rd(LCPS_SEL_ADDR, 32'h0040_1234, d);
      chk(d, 32'h0040_1234);
      chk({24'h0, pad_oe}, {24'h0, gpio_oe});
      $display("test read back done");

      // reset in mid-run returns every pin to gpio
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(LCPS_SEL_ADDR, d);
      chk(d, LCPS_SEL_RESET);
      repeat (8) @(posedge clk);
      #1;
      chk({24'h0, pad_out}, {24'h0, gpio_out});
      $display("test mid reset done");
      summarize();
   end
endmodule : lcps_pin_select_tb
`default_nettype wire
